//--- hw/flash_card_backup_controller.sv
// flash card program copy and data block backup sequencer

`timescale 1ns/1ns
`include "flash_card_backup_cfg.svh"
module flash_card_backup_controller #(
  parameter int unsigned HOLD_CYCLES = `FCB_HOLD_CYCLES,
  parameter int unsigned CARD_LATENCY = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // user program command port
  input wire logic i_system_write_command,
  input wire logic i_system_read_command,
  input wire flash_card_backup_pkg::command_type i_command,
  output logic o_accumulator,
  output logic o_error_flag,
  output logic o_read_valid,
  output logic [15:0] o_read_dest,
  output logic [31:0] o_read_data,
  // allocation request
  input wire logic i_alloc_valid,
  input wire flash_card_backup_pkg::alloc_kind_type i_alloc_kind,
  input wire logic [18:0] i_alloc_count,
  input wire logic [15:0] i_alloc_blocks,
  input wire logic [15:0] i_alloc_number,
  output logic o_alloc_ok,
  output logic o_alloc_refused,
  output logic [20:0] o_mem_used,
  // run control and configuration
  input wire logic i_load_switch,
  input wire logic i_startup,
  input wire logic i_ram_header_valid,
  input wire logic i_run_start,
  input wire logic i_backup_enabled,
  output logic o_cpu_stopped,
  // card side
  input wire logic i_card_present,
  input wire logic i_card_header_valid,
  input wire logic i_card_done,
  input wire logic i_card_fail,
  input wire logic i_card_length_mismatch,
  output logic o_card_copy_program,
  output logic o_card_erase_backup,
  output logic o_card_erase_sector,
  // block stream between ram and card
  input wire logic i_blk_valid,
  output logic o_blk_ready,
  input wire logic [31:0] i_blk_data,
  output logic o_card_valid,
  input wire logic i_card_ready,
  output logic [31:0] o_card_data
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PROG_COPY,
    ST_BACKUP,
    ST_RESTORE,
    ST_ERASE,
    ST_RECLAIM
  } state_type;

  state_type state_q;
  state_type state_d;
  logic [31:0] hold_q;
  logic [15:0] wait_q;
  logic [7:0] diag_q;
  logic [7:0] diag_d;

  logic err_q;
  logic stopped_q;
  logic startup_q;
  logic [17:0] backup_used_q;
  logic [20:0] used_q;
  // one entry is enough to spot a back-to-back resave; older copies age out by reclaim
  flash_card_backup_pkg::save_entry_type last_saved_q;

  // ----------------------------------------
  // allocation sizing
  // ----------------------------------------
  function automatic logic hi_range(input logic [15:0] n);
    hi_range = n >= `FCB_HI_FIRST && n <= `FCB_HI_LAST;
  endfunction
  function automatic logic [20:0] alloc_bytes(input flash_card_backup_pkg::alloc_kind_type k,
      input logic [18:0] n, input logic [15:0] b, input logic [15:0] num);
    logic [20:0] c;
    c = {2'b00, n};
    case (k)
      flash_card_backup_pkg::ALLOC_PROGRAM: alloc_bytes = 21'(c * `FCB_LINE_BYTES);
      flash_card_backup_pkg::ALLOC_TEXT: alloc_bytes = 21'(c * `FCB_CHAR_BYTES);
      default: begin
        if (hi_range(num)) begin
          alloc_bytes = 21'(c * `FCB_HI_REG_BYTES + {5'h00, b} * `FCB_HI_DESC_BYTES);
        end else begin
          alloc_bytes = 21'(c * `FCB_LO_REG_BYTES + {5'h00, b} * `FCB_LO_DESC_BYTES);
        end
      end
    endcase
  endfunction
  wire [21:0] alloc_total = {1'b0, used_q} +
      {1'b0, alloc_bytes(i_alloc_kind, i_alloc_count, i_alloc_blocks, i_alloc_number)};
  wire alloc_fit = alloc_total <= {1'b0, `FCB_RAM_BYTES};

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  wire busy = state_q != ST_IDLE;
  wire is_backup = i_command.func == `FCB_FN_BACKUP;
  wire is_restore = i_command.func == `FCB_FN_RESTORE;
  wire is_erase = i_command.func == `FCB_FN_ERASE;
  wire cmd_valid = i_system_write_command && (is_backup || is_restore || is_erase);
  wire num_ok = hi_range(i_command.operand);
  wire dest_ok = i_command.operand <= `FCB_DEST_LAST;
  wire test_read = i_system_read_command && i_command.func == `FCB_FN_BACKUP;
  wire hold_done = hold_q >= HOLD_CYCLES;
  wire card_ok = i_card_present && i_card_header_valid;
  wire auto_copy = startup_q && !i_ram_header_valid;
  wire wait_done = wait_q >= 16'(CARD_LATENCY);
  wire space_full = backup_used_q >= `FCB_BACKUP_BYTES;
  wire start_cmd = cmd_valid && !busy && i_card_present && i_backup_enabled && num_ok;
  wire card_take = o_card_valid && i_card_ready;
  wire resave = start_cmd && is_backup && i_command.operand == last_saved_q.number;
  wire [17:0] old_bytes = {last_saved_q.length, 2'b00};
  wire [17:0] sector_freed = space_full ? backup_used_q - `FCB_SECTOR_BYTES : '0;
  // a reclaim may already have returned the old copy's space
  wire give_back = resave && backup_used_q >= old_bytes;

  // ----------------------------------------
  // next state and diagnostics
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    diag_d = diag_q;
    if (cmd_valid && busy) begin
      diag_d[`FCB_DG_BUSY] = 1'b1;
    end else if (cmd_valid) begin
      diag_d[`FCB_DG_NO_CARD] = !i_card_present;
      diag_d[`FCB_DG_NO_HEADER] = !i_card_header_valid;
      diag_d[`FCB_DG_NOT_ENABLED] = !i_backup_enabled;
      diag_d[`FCB_DG_NOT_PRESENT] = !num_ok && !is_erase;
    end
    case (state_q)
      ST_IDLE: begin
        if ((hold_done || auto_copy) && card_ok) begin
          state_d = ST_PROG_COPY;
        end else if (start_cmd && is_erase) begin
          state_d = ST_ERASE;
        end else if (start_cmd && is_restore) begin
          state_d = ST_RESTORE;
        end else if (start_cmd && space_full) begin
          state_d = ST_RECLAIM;
        end else if (start_cmd) begin
          state_d = ST_BACKUP;
        end
      end
      ST_RECLAIM: begin
        if (i_card_done) begin
          state_d = ST_BACKUP;
        end
      end
      default: begin
        if (i_card_fail || (i_card_done && wait_done)) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    if (busy && i_card_fail) begin
      diag_d[`FCB_DG_RESTORED] = state_q == ST_BACKUP;
      diag_d[`FCB_DG_FULL] = state_q == ST_RECLAIM;
    end
    if (busy && i_card_length_mismatch) begin
      diag_d[`FCB_DG_FORMAT] = 1'b1;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      hold_q <= '0;
      wait_q <= '0;
      diag_q <= '0;
      err_q <= 1'b0;
      stopped_q <= 1'b1;
      startup_q <= 1'b0;
      backup_used_q <= '0;
      used_q <= '0;
      last_saved_q <= '0;
    end else begin
      state_q <= state_d;
      diag_q <= diag_d;
      startup_q <= i_startup;
      // a press still held when the copy ends starts another copy
      if (!i_load_switch) begin
        hold_q <= '0;
      end else if (!hold_done) begin
        hold_q <= hold_q + 32'd1;
      end
      // outside reclaim, card done only counts once the minimum card latency has passed
      if (state_q != state_d) begin
        wait_q <= '0;
      end else if (!wait_done) begin
        wait_q <= wait_q + 16'd1;
      end
      err_q <= (diag_d != '0) || (busy && i_card_fail);
      if (state_d == ST_PROG_COPY) begin
        stopped_q <= 1'b1;
      end else if (i_run_start && !busy) begin
        stopped_q <= 1'b0;
      end
      if (state_q == ST_PROG_COPY || state_q == ST_ERASE) begin
        backup_used_q <= '0;
      end else if (state_q == ST_RECLAIM && i_card_done) begin
        backup_used_q <= sector_freed;
      end else if (give_back) begin
        backup_used_q <= backup_used_q - old_bytes;
      end else if (state_q == ST_BACKUP && card_take) begin
        backup_used_q <= backup_used_q + 18'd4;
      end
      if (state_q == ST_PROG_COPY || state_q == ST_ERASE) begin
        last_saved_q <= '0;
      end else if (start_cmd && is_backup) begin
        last_saved_q <= {i_command.operand, 16'h0000};
      end else if (state_q == ST_BACKUP && card_take) begin
        last_saved_q.length <= last_saved_q.length + 16'h0001;
      end
      if (i_alloc_valid && alloc_fit) begin
        used_q <= alloc_total[20:0];
      end
    end
  end

  // ----------------------------------------
  // data path
  // ----------------------------------------
  wire stream_on = state_q == ST_BACKUP || state_q == ST_RESTORE || state_q == ST_PROG_COPY;
  logic fifo_in_ready;
  logic fifo_out_valid;
  // the fifo absorbs card write stalls; the source sees its ready
  fcb_fifo #(.WIDTH(32), .DEPTH(8)) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_blk_valid && stream_on),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_blk_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_card_ready),
    .o_out_data(o_card_data)
  );
  assign o_blk_ready = fifo_in_ready && stream_on;
  assign o_card_valid = fifo_out_valid;

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_read_valid <= 1'b0;
      o_read_dest <= '0;
      o_read_data <= '0;
      o_alloc_ok <= 1'b0;
      o_alloc_refused <= 1'b0;
    end else begin
      o_read_valid <= test_read && dest_ok;
      o_read_dest <= test_read ? i_command.operand : o_read_dest;
      o_read_data <= test_read ? {24'h000000, diag_q} : o_read_data;
      o_alloc_ok <= i_alloc_valid && alloc_fit;
      o_alloc_refused <= i_alloc_valid && !alloc_fit;
    end
  end
  assign o_accumulator = busy;
  assign o_error_flag = err_q;
  assign o_mem_used = used_q;
  assign o_cpu_stopped = stopped_q;
  assign o_card_copy_program = state_q == ST_PROG_COPY;
  assign o_card_erase_backup = state_q == ST_PROG_COPY || state_q == ST_ERASE;
  assign o_card_erase_sector = state_q == ST_RECLAIM;
endmodule

//--- hw/flash_card_backup_cfg.svh
// constants for the flash card backup controller
`ifndef FLASH_CARD_BACKUP_CFG_SVH
`define FLASH_CARD_BACKUP_CFG_SVH
`define FCB_RAM_BYTES 21'h100000
`define FCB_LINE_BYTES 21'h000004
`define FCB_CHAR_BYTES 21'h000001
`define FCB_HI_REG_BYTES 21'h000004
`define FCB_HI_DESC_BYTES 21'h000008
`define FCB_LO_REG_BYTES 21'h000008
`define FCB_LO_DESC_BYTES 21'h000003
`define FCB_HI_FIRST 16'h0fa0
`define FCB_HI_LAST 16'h1f3f
`define FCB_LO_LAST 16'h0f9f
`define FCB_FN_BACKUP 16'h2328
`define FCB_FN_RESTORE 16'h2329
`define FCB_FN_ERASE 16'h232a
`define FCB_DEST_LAST 16'h0fff
`define FCB_BACKUP_BYTES 18'h10000
`define FCB_SECTOR_BYTES 18'h10000
`define FCB_HOLD_MS 32'd3000
`define FCB_CLK_KHZ 32'd50000
`define FCB_HOLD_CYCLES (`FCB_HOLD_MS * `FCB_CLK_KHZ)
`define FCB_DG_NO_CARD 0
`define FCB_DG_NO_HEADER 1
`define FCB_DG_NOT_ENABLED 2
`define FCB_DG_NOT_PRESENT 3
`define FCB_DG_FORMAT 4
`define FCB_DG_RESTORED 5
`define FCB_DG_FULL 6
`define FCB_DG_BUSY 7
`endif

//--- hw/flash_card_backup_pkg.sv
// types for the flash card backup controller
package flash_card_backup_pkg;
  typedef enum logic [1:0] {
    ALLOC_PROGRAM,
    ALLOC_TEXT,
    ALLOC_DATA_BLOCK
  } alloc_kind_type;
  typedef struct packed {
    logic [15:0] func;
    logic [15:0] operand;
  } command_type;
  typedef struct packed {
    logic [15:0] number;
    logic [15:0] length;
  } save_entry_type;
endpackage

//--- hw/fcb_fifo.sv
// small valid/ready fifo
`timescale 1ns/1ns
module fcb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = cnt_q != (AW+1)'(DEPTH);
  assign o_out_valid = cnt_q != '0;
  assign o_out_data = mem[rp_q];
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wp_q] <= i_in_data;
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      if (pop) rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

//--- test/flash_card_backup_controller_sva.sv
// assertions for the flash card backup controller
`timescale 1ns/1ns
`include "flash_card_backup_cfg.svh"
module flash_card_backup_controller_sva (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_system_write_command,
  input wire logic i_system_read_command,
  input wire flash_card_backup_pkg::command_type i_command,
  input wire logic o_accumulator,
  input wire logic o_error_flag,
  input wire logic o_read_valid,
  input wire logic [15:0] o_read_dest,
  input wire logic [31:0] o_read_data,
  input wire logic i_alloc_valid,
  input wire flash_card_backup_pkg::alloc_kind_type i_alloc_kind,
  input wire logic [18:0] i_alloc_count,
  input wire logic o_alloc_ok,
  input wire logic o_alloc_refused,
  input wire logic [20:0] o_mem_used,
  input wire logic i_run_start,
  input wire logic i_backup_enabled,
  input wire logic o_cpu_stopped,
  input wire logic i_card_present,
  input wire logic i_card_done,
  input wire logic i_card_fail,
  input wire logic o_card_copy_program
);
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  wire idle_wr = i_system_write_command && !o_accumulator;
  wire bk_wr = idle_wr && i_command.func == `FCB_FN_BACKUP;
  wire num_ok = i_command.operand >= `FCB_HI_FIRST && i_command.operand <= `FCB_HI_LAST;
  wire code_ok = i_command.func >= `FCB_FN_BACKUP && i_command.func <= `FCB_FN_ERASE;
  wire [21:0] prog_sum = {3'h0, i_alloc_count} * 22'h4 + {1'b0, o_mem_used};
  wire [21:0] text_sum = {3'h0, i_alloc_count} + {1'b0, o_mem_used};
  wire is_prog = i_alloc_kind == flash_card_backup_pkg::ALLOC_PROGRAM;
  wire is_text = i_alloc_kind == flash_card_backup_pkg::ALLOC_TEXT;
  AST_REFUSE: assert property (
    i_alloc_valid && is_prog && prog_sum > 22'h100000 |=> o_alloc_refused && $stable(o_mem_used))
    else $error("oversize program allocation not refused");
  AST_TEXT: assert property (
    i_alloc_valid && is_text && text_sum <= 22'h100000
    |=> o_alloc_ok && o_mem_used == $past(o_mem_used) + 21'($past(i_alloc_count)))
    else $error("text allocation size wrong");
  AST_START: assert property (
    idle_wr && code_ok && num_ok && i_card_present && i_backup_enabled |=> o_accumulator)
    else $error("valid card command did not start");
  AST_ACCU_HOLD: assert property (
    o_accumulator && !i_card_done && !i_card_fail |=> o_accumulator)
    else $error("busy dropped before card finished");
  AST_BAD_NUM: assert property (
    bk_wr && !num_ok |=> !o_accumulator ##[0:1] o_error_flag)
    else $error("out of range number accepted");
  AST_NO_CARD: assert property (
    bk_wr && (!i_card_present || !i_backup_enabled) |=> !o_accumulator ##[0:1] o_error_flag)
    else $error("backup without card or enable accepted");
  AST_BUSY_CMD: assert property (
    i_system_write_command && code_ok && o_accumulator |-> ##[1:2] o_error_flag)
    else $error("command while busy not flagged");
  AST_READ: assert property (
    i_system_read_command && i_command.func == `FCB_FN_BACKUP
    && i_command.operand <= `FCB_DEST_LAST
    |=> o_read_valid && o_read_dest == $past(i_command.operand))
    else $error("card test read answer wrong");
  AST_RESERVED: assert property (
    o_read_valid |-> o_read_data[31:8] == 24'h000000)
    else $error("reserved diagnostic bits set");
  AST_COPY_STOP: assert property (
    o_card_copy_program |-> o_cpu_stopped)
    else $error("running during program copy");
  AST_STAY_STOP: assert property (
    $fell(o_cpu_stopped) |-> $past(i_run_start))
    else $error("left stop without start");
  cover property (bk_wr ##1 o_accumulator);
  cover property (o_alloc_refused);
  cover property (o_card_copy_program);
endmodule
bind flash_card_backup_controller flash_card_backup_controller_sva chk (.*);

//--- test/flash_card_model.sv
// flash card stand-in for the controller's card side
`timescale 1ns/1ns
module flash_card_model #(
  parameter int LAT = 20
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_fitted,
  input wire logic i_stall,
  input wire logic i_busy,
  output logic o_present,
  output logic o_header_valid,
  output logic o_done,
  output logic o_ready
);
  // ----------------
  // card behaviour
  // ----------------
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  assign o_present = i_fitted;
  assign o_header_valid = i_fitted;
  assign o_ready = !i_stall;
  // a stalled card neither takes words nor finishes, like a slow sector write
  assign o_done = i_busy && cnt_q == 8'(LAT);
  assign cnt_d = (i_busy && !i_stall && !o_done) ? cnt_q + 8'h01 : 8'h00;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

//--- test/tb.sv
// self-checking bench for the flash card backup controller
`timescale 1ns/1ns
`include "flash_card_backup_cfg.svh"
module tb;
  logic i_clk_sys, i_sys_rst, i_system_write_command, i_system_read_command, o_accumulator;
  logic o_error_flag, o_read_valid, o_alloc_ok, o_alloc_refused, i_alloc_valid, i_load_switch;
  logic i_startup, i_ram_header_valid, i_run_start, i_backup_enabled, o_cpu_stopped;
  logic i_card_present, i_card_header_valid, i_card_done, i_card_fail, i_card_length_mismatch;
  logic o_card_copy_program, o_card_erase_backup, o_card_erase_sector, i_blk_valid, o_blk_ready;
  logic o_card_valid, i_card_ready, fitted, stall, saw_erase;
  logic [15:0] o_read_dest, i_alloc_blocks, i_alloc_number;
  logic [31:0] o_read_data, i_blk_data, o_card_data, rd_q;
  logic [18:0] i_alloc_count;
  logic [20:0] o_mem_used, used_exp;
  flash_card_backup_pkg::command_type i_command;
  flash_card_backup_pkg::alloc_kind_type i_alloc_kind;
  int err_count, check_count, cyc, k, sent, rx_n, copy_n;
  // ----------------
  // harness and tests
  // ----------------
  flash_card_backup_controller #(.HOLD_CYCLES(20)) DUT (.*);
  flash_card_model #(.LAT(20)) card (.i_clk_sys, .i_sys_rst, .i_fitted(fitted), .i_stall(stall),
    .i_busy(o_accumulator | o_card_copy_program | o_card_erase_backup | o_card_erase_sector),
    .o_present(i_card_present), .o_header_valid(i_card_header_valid), .o_done(i_card_done),
    .o_ready(i_card_ready));
  initial begin
    i_clk_sys = 0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task chk(input string name, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wr(input logic [15:0] f, op);
    @(negedge i_clk_sys);
    i_command = {f, op};
    i_system_write_command = 1;
    @(negedge i_clk_sys);
    i_system_write_command = 0;
  endtask
  task rd(input logic [15:0] op);
    @(negedge i_clk_sys);
    i_command = {`FCB_FN_BACKUP, op};
    i_system_read_command = 1;
    @(negedge i_clk_sys);
    i_system_read_command = 0;
    chk("read_valid", o_read_valid, 1);
    chk("read_dest", o_read_dest, op);
    rd_q = o_read_data;
    chk("diag_rsv", rd_q[31:8], 0);
  endtask
  task al(input flash_card_backup_pkg::alloc_kind_type kd, input logic [18:0] c,
    input logic [15:0] b, n, input logic [20:0] bytes, input logic ok);
    @(negedge i_clk_sys);
    i_alloc_kind = kd;
    {i_alloc_count, i_alloc_blocks, i_alloc_number} = {c, b, n};
    i_alloc_valid = 1;
    @(negedge i_clk_sys);
    i_alloc_valid = 0;
    chk("alloc_ok", o_alloc_ok, ok);
    chk("alloc_refused", o_alloc_refused, !ok);
    if (ok) used_exp = used_exp + bytes;
    chk("mem_used", o_mem_used, used_exp);
  endtask
  task bad(input logic fit, en, input logic [15:0] op, input int bn);
    fitted = fit;
    i_backup_enabled = en;
    wr(`FCB_FN_BACKUP, op);
    chk("not_started", o_accumulator, 0);
    rd(16'h0001);
    chk("diag_bit", rd_q[bn], 1);
    chk("err_flag", o_error_flag, 1);
    fitted = 1;
    i_backup_enabled = 1;
  endtask
  task idle_wait();
    for (k = 0; k < 300 && (o_accumulator !== 0 || o_card_copy_program !== 0); k++)
      @(negedge i_clk_sys);
  endtask
  task run_pulse();
    @(negedge i_clk_sys);
    i_run_start = 1;
    @(negedge i_clk_sys);
    i_run_start = 0;
  endtask
  always @(posedge i_clk_sys) begin
    cyc++;
    if (o_card_copy_program === 1) copy_n++;
    if (o_card_erase_backup === 1) saw_erase = 1;
    if (o_card_valid === 1 && i_card_ready === 1) begin
      chk("card_data", o_card_data, 32'h00c00000 + rx_n);
      rx_n++;
    end
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    {i_system_write_command, i_system_read_command, i_alloc_valid, i_load_switch} = '0;
    {i_run_start, i_ram_header_valid, i_card_fail, i_card_length_mismatch} = '0;
    {i_blk_valid, stall, saw_erase, i_command, i_blk_data, used_exp} = '0;
    i_alloc_kind = flash_card_backup_pkg::ALLOC_PROGRAM;
    {i_alloc_count, i_alloc_blocks, i_alloc_number} = '0;
    {i_sys_rst, fitted, i_startup, i_backup_enabled} = 4'hf;
    repeat (12) @(negedge i_clk_sys);
    i_sys_rst = 0;
    chk("stopped_rst", o_cpu_stopped, 1);
    for (k = 0; k < 20 && o_card_copy_program !== 1; k++) @(negedge i_clk_sys);
    chk("auto_copy", o_card_copy_program, 1);
    {i_startup, i_ram_header_valid} = 2'h1;
    idle_wait();
    chk("copy_stop", o_cpu_stopped, 1);
    chk("copy_erase", saw_erase, 1);
    run_pulse();
    chk("run", o_cpu_stopped, 0);
    sent = copy_n;
    i_load_switch = 1;
    repeat (10) @(negedge i_clk_sys);
    i_load_switch = 0;
    repeat (30) @(negedge i_clk_sys);
    chk("short_hold", copy_n, sent);
    i_load_switch = 1;
    for (k = 0; k < 40 && o_card_copy_program !== 1; k++) @(negedge i_clk_sys);
    i_load_switch = 0;
    chk("hold_len", k >= 20 && o_card_copy_program === 1, 1);
    idle_wait();
    chk("load_stop", o_cpu_stopped, 1);
    run_pulse();
    al(flash_card_backup_pkg::ALLOC_PROGRAM, 1000, 0, 0, `FCB_LINE_BYTES * 21'd1000, 1);
    al(flash_card_backup_pkg::ALLOC_TEXT, 5, 0, 0, `FCB_CHAR_BYTES * 21'd5, 1);
    al(flash_card_backup_pkg::ALLOC_DATA_BLOCK, 10, 2, `FCB_HI_LAST,
      `FCB_HI_REG_BYTES * 21'd10 + `FCB_HI_DESC_BYTES * 21'd2, 1);
    al(flash_card_backup_pkg::ALLOC_DATA_BLOCK, 10, 2, `FCB_LO_LAST,
      `FCB_LO_REG_BYTES * 21'd10 + `FCB_LO_DESC_BYTES * 21'd2, 1);
    al(flash_card_backup_pkg::ALLOC_PROGRAM, 19'h40000, 0, 0, 21'h0, 0);
    al(flash_card_backup_pkg::ALLOC_TEXT, 19'h7ffff, 0, 0, 21'h7ffff, 1);
    for (int f = 0; f < 3; f++) begin
      rd(f == 2 ? `FCB_DEST_LAST : 16'h0000);
      chk("ready", o_accumulator, 0);
      wr(`FCB_FN_BACKUP + 16'(f), `FCB_HI_FIRST);
      chk("accu_busy", o_accumulator, 1);
      idle_wait();
      chk("accu_ready", o_accumulator, 0);
    end
    wr(`FCB_FN_BACKUP, `FCB_HI_FIRST);
    {i_card_fail, i_card_length_mismatch} = 2'h3;
    @(negedge i_clk_sys);
    {i_card_fail, i_card_length_mismatch} = 2'h0;
    idle_wait();
    chk("fail_err", o_error_flag, 1);
    rd(16'h0005);
    chk("len_bit", rd_q[4], 1);
    bad(1, 1, `FCB_LO_LAST, 3);
    bad(0, 1, `FCB_HI_FIRST, 0);
    bad(1, 0, `FCB_HI_FIRST, 2);
    stall = 1;
    wr(`FCB_FN_BACKUP, `FCB_HI_LAST);
    sent = 0;
    repeat (12) begin
      @(negedge i_clk_sys);
      i_blk_data = 32'h00c00000 + sent;
      i_blk_valid = o_blk_ready;
      if (o_blk_ready === 1) sent++;
    end
    @(negedge i_clk_sys);
    i_blk_valid = 0;
    chk("fifo_fill", sent, 8);
    chk("accu_stall", o_accumulator, 1);
    wr(`FCB_FN_RESTORE, `FCB_HI_FIRST);
    stall = 0;
    for (k = 0; k < 300 && (o_accumulator !== 0 || rx_n < 8); k++) @(negedge i_clk_sys);
    chk("drained", rx_n, 8);
    chk("empty", o_card_valid, 0);
    chk("no_restart", o_accumulator, 0);
    rd(16'h0002);
    chk("diag_busy", rd_q[7], 1);
    chk("no_reclaim", o_card_erase_sector, 0);
    stop_test();
  end
endmodule
